/* acr_pkg.sv */
// Constants for the acquisition command register block.
// Assumes a 16-bit board I/O bus with a word-size qualifier on each write.
package acr_pkg;

  // Register map
  localparam logic [4:0] ACR_CMD_OFFSET = 5'h00;
  localparam int unsigned ACR_DATA_W = 16;
  localparam int unsigned ACR_ADDR_W = 5;
  // Lowest implemented bit; bits below are reserved and not stored
  localparam int unsigned ACR_LOW_BIT = 4;

  // Field positions of the command word
  localparam int unsigned ACR_BIT_CAL_STORE_SELECT = 15;
  localparam int unsigned ACR_BIT_SERIAL_OUT_BIT = 14;
  localparam int unsigned ACR_BIT_SERIAL_CLOCK = 13;
  localparam int unsigned ACR_BIT_SEQUENCE_BY_COUNTER = 12;
  localparam int unsigned ACR_BIT_DITHER = 11;
  localparam int unsigned ACR_BIT_CONVERSION_INHIBIT = 10;
  localparam int unsigned ACR_BIT_REARM_LOCKOUT = 9;
  localparam int unsigned ACR_BIT_ACQUISITION_ENABLE = 8;
  localparam int unsigned ACR_BIT_MULTI_CHANNEL_ENABLE = 7;
  localparam int unsigned ACR_BIT_INTERVAL_SCAN_SELECT = 6;
  localparam int unsigned ACR_BIT_WIDE_COUNT_SELECT = 5;
  localparam int unsigned ACR_BIT_SYNC_BUS_TRIGGER_ENABLE = 4;

  // Calibration DAC shift path
  localparam int unsigned ACR_CAL_DAC_W = 8;
  localparam int unsigned ACR_CAL_DAC_N = 2;

  // Idle levels after reset
  localparam logic ACR_EXT_TRIG_IDLE = 1'b1;

  // Acquisition sequencing states
  typedef enum logic [1:0] {
    ACR_IDLE = 2'b00,
    ACR_RUN = 2'b01,
    ACR_HOLD = 2'b10
  } acr_state_e;

endpackage : acr_pkg

/* acr_cal_dac_shift.sv */
// Shared serial shift path into the calibration DACs with per-DAC load.
// Assumes shift and load strobes are one-cycle pulses on CLK.
`timescale 1ns/1ps
module acr_cal_dac_shift
  import acr_pkg::*;
#(
  parameter int unsigned WIDTH = ACR_CAL_DAC_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic shift,
  input wire logic data,
  input wire logic [ACR_CAL_DAC_N-1:0] load,
  output logic [WIDTH-1:0] dac0_value,
  output logic [WIDTH-1:0] dac1_value
);

  logic [WIDTH-1:0] shreg;
  logic [WIDTH-1:0] next_shreg;
  logic [WIDTH-1:0] next_dac0_value;
  logic [WIDTH-1:0] next_dac1_value;

  ////////////////////////////////////////////////////////////////////////////
  // Shifted bits stay hidden until the matching load strobe
  always_comb begin
    next_shreg = shreg;
    next_dac0_value = dac0_value;
    next_dac1_value = dac1_value;
    if (shift) begin
      next_shreg = {shreg[WIDTH-2:0], data};
    end
    if (load[0]) begin
      next_dac0_value = shreg;
    end
    if (load[1]) begin
      next_dac1_value = shreg;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shreg <= '0;
      dac0_value <= '0;
      dac1_value <= '0;
    end else begin
      shreg <= next_shreg;
      dac0_value <= next_dac0_value;
      dac1_value <= next_dac1_value;
    end
  end

endmodule : acr_cal_dac_shift

/* acr_trigger_ctl.sv */
// Trigger selection and acquisition-in-progress sequencing.
// Assumes all trigger inputs are synchronous to clk.
`timescale 1ns/1ps
module acr_trigger_ctl
  import acr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic acquisition_enable,
  input wire logic rearm_lockout,
  input wire logic sync_bus_trigger_enable,
  input wire logic start_strobe,
  input wire logic external_trigger_n,
  input wire logic sync_bus_trigger,
  input wire logic sequence_done,
  input wire logic progress_clear,
  output logic counters_start,
  output logic acquisition_in_progress
);

  acr_state_e state;
  acr_state_e next_state;
  logic ext_prev;
  logic next_ext_prev;
  logic next_counters_start;
  logic ext_fall;
  logic trigger;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger source select, then accept only when idle
  always_comb begin
    next_ext_prev = external_trigger_n;
    ext_fall = ext_prev & ~external_trigger_n;
    if (sync_bus_trigger_enable) begin
      trigger = sync_bus_trigger;
    end else begin
      trigger = start_strobe | ext_fall;
    end
    next_state = state;
    next_counters_start = 1'b0;
    unique case (state)
      ACR_IDLE: begin
        if (trigger && acquisition_enable) begin
          next_counters_start = 1'b1;
          next_state = ACR_RUN;
        end
      end
      ACR_RUN: begin
        if (sequence_done) begin
          // Lockout holds the status until software acknowledges it
          next_state = rearm_lockout ? ACR_HOLD : ACR_IDLE;
        end
      end
      ACR_HOLD: begin
        if (progress_clear) begin
          next_state = ACR_IDLE;
        end
      end
      default: begin
        next_state = ACR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ACR_IDLE;
      ext_prev <= ACR_EXT_TRIG_IDLE;
      counters_start <= 1'b0;
    end else begin
      state <= next_state;
      ext_prev <= next_ext_prev;
      counters_start <= next_counters_start;
    end
  end

  assign acquisition_in_progress = (state != ACR_IDLE);

endmodule : acr_trigger_ctl

/* acr_command.sv */
// Acquisition command register: write-only control word at offset zero.
// Assumes a synchronous board I/O write strobe and word-size qualifier.
// Assumes the status and counter logic around it consume the pulse outputs.
//
// What this block does
// - Register is a 16-bit write-only word at I/O offset zero.
// - Contents undefined at power up, untouched by reset; software initialises.
// - Bit 15 one asserts the calibration store chip select.
// - Bit 14 is the shared serial data line.
// - Rising bit 13 shifts data into store when selected, always into DACs.
// - With store select low, serial clock toggles do not reach the store.
// - Shifted DAC bits only appear after that DAC's load strobe.
// - Bit 12 picks channel memory advance: counter 1 or each conversion.
// - Bit 11 enables half-LSB dither noise on the selected input.
// - Bit 10 one suppresses all internal and external conversions.
// - Bit 9 holds off new triggers until progress status is cleared.
// - Bit 8 lets start strobe or external trigger start the counters.
// - Bit 7 with enable steps channels; clear samples one channel.
// - Scan step output is active only while scan enable is one.
// - Bit 6 runs one scan per interval; clear repeats back to back.
// - Bit 5 chains counters 4 and 5 into a 32-bit count.
// - Bit 4 takes triggers from the sync bus, disabling local sources.
// - External trigger acts on its falling edge.
`timescale 1ns/1ps
module acr_command
  import acr_pkg::*;
#(
  parameter int unsigned CAL_DAC_W = ACR_CAL_DAC_W
) (
  input wire logic CLK,
  input wire logic RESETN,
  // Board I/O write port
  input wire logic [ACR_ADDR_W-1:0] IO_ADDR,
  input wire logic [ACR_DATA_W-1:0] IO_WDATA,
  input wire logic IO_WR,
  input wire logic IO_WORD,
  // Calibration serial lines
  output logic CAL_STORE_SELECT,
  output logic SERIAL_OUT_BIT,
  output logic CAL_STORE_CLOCK,
  output logic CAL_DAC_SHIFT,
  input wire logic [ACR_CAL_DAC_N-1:0] CAL_DAC_LOAD,
  output logic [CAL_DAC_W-1:0] CAL_DAC0_VALUE,
  output logic [CAL_DAC_W-1:0] CAL_DAC1_VALUE,
  // Analog front end
  output logic DITHER_ENABLE,
  input wire logic CONVERT_REQUEST,
  output logic CONVERT_START,
  // Channel sequencing and scanning
  input wire logic COUNTER1_TICK,
  output logic CHANNEL_ADVANCE,
  output logic SCAN_STEP_OUTPUT,
  input wire logic SCAN_INTERVAL_TICK,
  input wire logic SCAN_CYCLE_END,
  output logic SCAN_CYCLE_GATE,
  // Conversion counting
  input wire logic COUNTER4_TC,
  input wire logic COUNTER5_TC,
  output logic WIDE_COUNT_SELECT,
  output logic COUNTER5_ENABLE,
  // Triggering
  input wire logic START_STROBE,
  input wire logic EXTERNAL_TRIGGER_N,
  input wire logic SYNC_BUS_TRIGGER,
  input wire logic PROGRESS_CLEAR,
  output logic COUNTERS_START,
  output logic ACQUISITION_IN_PROGRESS
);

  ////////////////////////////////////////////////////////////////////////////
  // Command word storage
  // Software must load every held bit once after power up; until then the
  // outputs that copy the word are unknown

  logic [ACR_DATA_W-1:ACR_LOW_BIT] cmd;
  logic [ACR_DATA_W-1:ACR_LOW_BIT] next_cmd;
  logic cmd_write;

  // Only a word write to offset zero is taken; byte access is invalid here
  // A byte write to this word leaves every held bit untouched
  always_comb begin
    cmd_write = IO_WR && IO_WORD && (IO_ADDR == ACR_CMD_OFFSET);
    next_cmd = cmd;
    if (cmd_write) begin
      // Reserved low bits are dropped, software keeps them zero
      next_cmd = IO_WDATA[ACR_DATA_W-1:ACR_LOW_BIT];
    end
  end

  // No reset on purpose: the word survives a board reset
  always_ff @(posedge CLK) begin
    cmd <= next_cmd;
  end

  // Named views of the fields
  // One name per field keeps the bit positions in the package only
  logic f_store_sel;
  logic f_serial_bit;
  logic f_sclk;
  logic f_seq_by_ctr;
  logic f_dither;
  logic f_inhibit;
  logic f_lockout;
  logic f_acq_en;
  logic f_multi;
  logic f_interval;
  logic f_wide;
  logic f_sync_trig;

  // Pure wiring, kept as one process so every view has a single driver
  always_comb begin
    f_store_sel = cmd[ACR_BIT_CAL_STORE_SELECT];
    f_serial_bit = cmd[ACR_BIT_SERIAL_OUT_BIT];
    f_sclk = cmd[ACR_BIT_SERIAL_CLOCK];
    f_seq_by_ctr = cmd[ACR_BIT_SEQUENCE_BY_COUNTER];
    f_dither = cmd[ACR_BIT_DITHER];
    f_inhibit = cmd[ACR_BIT_CONVERSION_INHIBIT];
    f_lockout = cmd[ACR_BIT_REARM_LOCKOUT];
    f_acq_en = cmd[ACR_BIT_ACQUISITION_ENABLE];
    f_multi = cmd[ACR_BIT_MULTI_CHANNEL_ENABLE];
    f_interval = cmd[ACR_BIT_INTERVAL_SCAN_SELECT];
    f_wide = cmd[ACR_BIT_WIDE_COUNT_SELECT];
    f_sync_trig = cmd[ACR_BIT_SYNC_BUS_TRIGGER_ENABLE];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial calibration lines

  logic sclk_prev;
  logic next_sclk_prev;
  logic next_store_clock;
  logic next_dac_shift;
  logic sclk_rise;

  // Edge of the software-driven clock bit; the store only sees it while selected
  // The store clock copies the bit level; the DACs want a single-cycle shift
  // strobe, so only they see the edge detector
  always_comb begin
    next_sclk_prev = f_sclk;
    sclk_rise = f_sclk & ~sclk_prev;
    next_store_clock = f_sclk & f_store_sel;
    next_dac_shift = sclk_rise;
  end

  // Follows the word without a reset: the word survives a reset, so a reset
  // that cleared this copy could fake a rising clock bit and shift the DACs
  always_ff @(posedge CLK) begin
    sclk_prev <= next_sclk_prev;
  end

  // Output flops keep the store clock and shift strobe free of decode glitches
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CAL_STORE_CLOCK <= 1'b0;
      CAL_DAC_SHIFT <= 1'b0;
    end else begin
      CAL_STORE_CLOCK <= next_store_clock;
      CAL_DAC_SHIFT <= next_dac_shift;
    end
  end

  // Select and data straight from the held word
  // Plain wires: no added delay between a word write and the serial pins
  assign CAL_STORE_SELECT = f_store_sel;
  assign SERIAL_OUT_BIT = f_serial_bit;
  assign DITHER_ENABLE = f_dither;
  assign WIDE_COUNT_SELECT = f_wide;

  // Shift path and load strobes live in their own small block
  acr_cal_dac_shift #(
    .WIDTH(CAL_DAC_W)
  ) u_cal_dac (
    .clk(CLK),
    .resetn(RESETN),
    .shift(CAL_DAC_SHIFT),
    .data(f_serial_bit),
    .load(CAL_DAC_LOAD),
    .dac0_value(CAL_DAC0_VALUE),
    .dac1_value(CAL_DAC1_VALUE)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Conversion gating and channel sequencing

  logic next_convert_start;
  logic next_channel_advance;
  logic next_scan_step;
  logic conv_go;

  // Inhibit blocks every request, whatever its source
  // Limitation: a request that meets a write of the inhibit bit in the same
  // cycle is judged against the old word
  always_comb begin
    conv_go = CONVERT_REQUEST & ~f_inhibit;
    next_convert_start = conv_go;
    next_channel_advance = 1'b0;
    if (f_acq_en && f_multi) begin
      if (f_seq_by_ctr) begin
        next_channel_advance = COUNTER1_TICK;
      end else begin
        next_channel_advance = conv_go;
      end
    end
    // Connector scan clock only runs with scanning on
    next_scan_step = f_multi & next_channel_advance;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CONVERT_START <= 1'b0;
      CHANNEL_ADVANCE <= 1'b0;
      SCAN_STEP_OUTPUT <= 1'b0;
    end else begin
      CONVERT_START <= next_convert_start;
      CHANNEL_ADVANCE <= next_channel_advance;
      SCAN_STEP_OUTPUT <= next_scan_step;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan cycle pacing

  logic scan_armed;
  logic next_scan_armed;
  logic next_scan_gate;

  // Interval mode waits for the interval tick before each cycle;
  // continuous mode keeps the gate open so cycles follow back to back
  // Leaving interval mode disarms at once, so a stale tick cannot open
  // the gate when the mode comes back
  always_comb begin
    next_scan_armed = scan_armed;
    if (!(f_acq_en && f_multi && f_interval)) begin
      next_scan_armed = 1'b0;
    end else if (SCAN_INTERVAL_TICK) begin
      next_scan_armed = 1'b1;
    end else if (SCAN_CYCLE_END) begin
      next_scan_armed = 1'b0;
    end
    if (f_acq_en && f_multi) begin
      next_scan_gate = f_interval ? next_scan_armed : 1'b1;
    end else begin
      next_scan_gate = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      scan_armed <= 1'b0;
      SCAN_CYCLE_GATE <= 1'b0;
    end else begin
      scan_armed <= next_scan_armed;
      SCAN_CYCLE_GATE <= next_scan_gate;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion count width

  logic next_ctr5_enable;
  logic count_done;

  // Counter 5 only counts the carries of counter 4 in wide mode
  // In narrow mode counter 5 stays frozen, so it carries no stale count
  // into a later wide run
  always_comb begin
    next_ctr5_enable = f_wide & COUNTER4_TC;
    count_done = f_wide ? COUNTER5_TC : COUNTER4_TC;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      COUNTER5_ENABLE <= 1'b0;
    end else begin
      COUNTER5_ENABLE <= next_ctr5_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Triggering and progress status
  // The word is write-only, so progress is reported on its own pin for the
  // status path elsewhere on the board

  acr_trigger_ctl u_trigger (
    .clk(CLK),
    .resetn(RESETN),
    .acquisition_enable(f_acq_en),
    .rearm_lockout(f_lockout),
    .sync_bus_trigger_enable(f_sync_trig),
    .start_strobe(START_STROBE),
    .external_trigger_n(EXTERNAL_TRIGGER_N),
    .sync_bus_trigger(SYNC_BUS_TRIGGER),
    .sequence_done(count_done),
    .progress_clear(PROGRESS_CLEAR),
    .counters_start(COUNTERS_START),
    .acquisition_in_progress(ACQUISITION_IN_PROGRESS)
  );

endmodule : acr_command

/* acr_command_asserts.sv */
// Port checker for the acquisition command register.
// Assumes binding to acr_command: one clock, async active-low reset.
`timescale 1ns/1ps
module acr_command_asserts
  import acr_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [ACR_ADDR_W-1:0] IO_ADDR,
  input wire logic [ACR_DATA_W-1:0] IO_WDATA,
  input wire logic IO_WR,
  input wire logic IO_WORD,
  input wire logic CAL_STORE_SELECT,
  input wire logic CAL_STORE_CLOCK,
  input wire logic CAL_DAC_SHIFT,
  input wire logic CONVERT_REQUEST,
  input wire logic CONVERT_START,
  input wire logic SCAN_STEP_OUTPUT,
  input wire logic START_STROBE,
  input wire logic SYNC_BUS_TRIGGER,
  input wire logic PROGRESS_CLEAR,
  input wire logic COUNTERS_START,
  input wire logic ACQUISITION_IN_PROGRESS
);
  logic w;
  logic [5:0] hold;
  logic [5:0] next_hold;
  ////////////////////////////////////////////////////////////////
  // Accepted word write at the command offset
  assign w = IO_WR && IO_WORD && (IO_ADDR == ACR_CMD_OFFSET);
  // Shadow of bits 13,10,9,8,7,4; unreset, like the register
  always_comb begin
    next_hold = hold;
    if (w) next_hold = {IO_WDATA[13], IO_WDATA[10:7], IO_WDATA[4]};
  end
  always_ff @(posedge CLK) begin
    hold <= next_hold;
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Serial clock bit written from zero to one
  sequence s_rise;
    w && IO_WDATA[13] && !hold[5];
  endsequence
  sequence s_pulse;
    CAL_DAC_SHIFT ##1 !CAL_DAC_SHIFT;
  endsequence
  property p_sel;
    w |=> CAL_STORE_SELECT == $past(IO_WDATA[15]);
  endproperty
  a_sel: assert property (p_sel) else $error("select bit wrong");
  property p_sclk;
    !CAL_STORE_SELECT |=> !CAL_STORE_CLOCK;
  endproperty
  a_sclk: assert property (p_sclk) else $error("store clocked");
  property p_shift;
    s_rise |=> ##1 s_pulse;
  endproperty
  a_shift: assert property (p_shift) else $error("no shift pulse");
  property p_conv;
    CONVERT_REQUEST && hold[4] |=> !CONVERT_START;
  endproperty
  a_conv: assert property (p_conv) else $error("conversion leaked");
  property p_start;
    START_STROBE && hold[2] && !hold[0] && !ACQUISITION_IN_PROGRESS
      |=> COUNTERS_START && ACQUISITION_IN_PROGRESS;
  endproperty
  a_start: assert property (p_start) else $error("start ignored");
  property p_off;
    !hold[2] |=> !COUNTERS_START;
  endproperty
  a_off: assert property (p_off) else $error("start while off");
  property p_sync;
    hold[0] && !SYNC_BUS_TRIGGER |=> !COUNTERS_START;
  endproperty
  a_sync: assert property (p_sync) else $error("local trigger");
  property p_lock;
    hold[3] && ACQUISITION_IN_PROGRESS && !PROGRESS_CLEAR
      |=> ACQUISITION_IN_PROGRESS;
  endproperty
  a_lock: assert property (p_lock) else $error("lockout lost");
  property p_scan;
    !hold[1] [*2] |=> !SCAN_STEP_OUTPUT;
  endproperty
  a_scan: assert property (p_scan) else $error("scan step on");
endmodule : acr_command_asserts

bind acr_command acr_command_asserts u_chk (
  .CLK(CLK), .RESETN(RESETN), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA),
  .IO_WR(IO_WR), .IO_WORD(IO_WORD), .CAL_STORE_SELECT(CAL_STORE_SELECT),
  .CAL_STORE_CLOCK(CAL_STORE_CLOCK), .CAL_DAC_SHIFT(CAL_DAC_SHIFT),
  .CONVERT_REQUEST(CONVERT_REQUEST), .CONVERT_START(CONVERT_START),
  .SCAN_STEP_OUTPUT(SCAN_STEP_OUTPUT), .START_STROBE(START_STROBE),
  .SYNC_BUS_TRIGGER(SYNC_BUS_TRIGGER), .PROGRESS_CLEAR(PROGRESS_CLEAR),
  .COUNTERS_START(COUNTERS_START),
  .ACQUISITION_IN_PROGRESS(ACQUISITION_IN_PROGRESS)
);

/* test_acquisition_command_register.sv */
// Testbench for the acquisition command register.
// Assumes acr_command with its bound checker; drives every pin itself.
`timescale 1ns/1ps
module test_acquisition_command_register
  import acr_pkg::*;
;
  logic clk, resetn, wr, word;
  logic [4:0] addr;
  logic [15:0] wdata, d;
  logic [11:0] p;
  logic [4:0] seen;
  logic sel, sdo, sclk_o, shift, dith, cstart, adv, step, gate, wide, c5en, cs, busy;
  logic [7:0] dac0, dac1;
  int n_errors;
  int num_checks;
  ////////////////////////////////////////////////////////////////
  // Clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  acr_command DUT (
    .CLK(clk), .RESETN(resetn), .IO_ADDR(addr), .IO_WDATA(wdata), .IO_WR(wr),
    .IO_WORD(word), .CAL_STORE_SELECT(sel), .SERIAL_OUT_BIT(sdo),
    .CAL_STORE_CLOCK(sclk_o), .CAL_DAC_SHIFT(shift), .CAL_DAC_LOAD(p[11:10]),
    .CAL_DAC0_VALUE(dac0), .CAL_DAC1_VALUE(dac1), .DITHER_ENABLE(dith),
    .CONVERT_REQUEST(p[0]), .CONVERT_START(cstart), .COUNTER1_TICK(p[1]),
    .CHANNEL_ADVANCE(adv), .SCAN_STEP_OUTPUT(step), .SCAN_INTERVAL_TICK(p[2]),
    .SCAN_CYCLE_END(p[3]), .SCAN_CYCLE_GATE(gate), .COUNTER4_TC(p[4]),
    .COUNTER5_TC(p[5]), .WIDE_COUNT_SELECT(wide), .COUNTER5_ENABLE(c5en),
    .START_STROBE(p[6]), .EXTERNAL_TRIGGER_N(~p[9]), .SYNC_BUS_TRIGGER(p[7]),
    .PROGRESS_CLEAR(p[8]), .COUNTERS_START(cs), .ACQUISITION_IN_PROGRESS(busy)
  );
  ////////////////////////////////////////////////////////////////
  // Inputs move 1 ns after the edge, never on it
  task automatic cyc;
    @(posedge clk);
    #1;
  endtask : cyc
  // Strobe stays up after a write so back-to-back writes never toggle it in
  // one step; pulse drops it, and idle cycles meanwhile reload the same word
  task automatic wra(input logic [4:0] a, input logic wd, input logic [15:0] v);
    addr = a;
    word = wd;
    wdata = v;
    wr = 1'b1;
    cyc;
  endtask : wra
  task automatic wrc(input logic [15:0] v);
    wra(5'h00, 1'b1, v);
  endtask : wrc
  // One-cycle pulse; pulse outputs are gathered over three cycles
  task automatic pulse(input int i);
    wr = 1'b0;
    p[i] = 1'b1;
    cyc;
    p[i] = 1'b0;
    seen = '0;
    repeat (3) begin
      seen = seen | {c5en, step, adv, cstart, cs};
      cyc;
    end
  endtask : pulse
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic results;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge clk);
    n_errors++;
    results;
  end
  // Main sequence
  initial begin
    resetn = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    word = 1'b0;
    p = '0;
    n_errors = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    #1;
    resetn = 1'b1;
    // Back-to-back words land whole
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 16'hc820 : (i == 1) ? 16'h0000 : 16'h8800;
      wrc(d);
      chk({sel, sdo, dith, wide}, {d[15], d[14], d[11], d[5]});
    end
    wra(5'h02, 1'b1, 16'h0000);
    wra(5'h00, 1'b0, 16'h0000);
    chk({sel, dith}, 2'b11);
    resetn = 1'b0;
    cyc;
    resetn = 1'b1;
    cyc;
    chk({sel, dith}, 2'b11);
    $display("test fields done");
    // Serial lines: store clock gated by select, DAC shift and load
    wrc(16'h2000);
    wrc(16'h0000);
    chk(sclk_o, 1'b0);
    wrc(16'ha000);
    cyc;
    chk(sclk_o, 1'b1);
    chk(shift, 1'b1);
    for (int b = 7; b >= 0; b--) begin
      d = {1'b0, b[0] ^ b[1] ^ b[2] ? 1'b1 : 1'b0, 14'h0000};
      wrc(d);
      wrc(d | 16'h2000);
      cyc;
      cyc;
    end
    chk(dac0, 16'h0000);
    pulse(10);
    chk({dac0, dac1}, 16'h9600);
    pulse(11);
    chk(dac1, 16'h0096);
    $display("test serial done");
    // Conversion gate, channel advance source, scan step
    wrc(16'h1580);
    pulse(0);
    chk(seen[2:1], 2'b00);
    pulse(1);
    chk(seen[2], 1'b1);
    wrc(16'h0180);
    pulse(0);
    chk(seen[1], 1'b1);
    chk(seen[3:2], 2'b11);
    pulse(1);
    chk(seen[2], 1'b0);
    wrc(16'h0100);
    pulse(0);
    chk(seen[3:1], 3'b001);
    wrc(16'h0180);
    cyc;
    chk(gate, 1'b1);
    wrc(16'h01c0);
    pulse(3);
    chk(gate, 1'b0);
    pulse(2);
    chk(gate, 1'b1);
    $display("test scan done");
    // Every trigger source under each enable and source mode
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 3; k++) begin
        d = (m == 0) ? 16'h0000 : (m == 1) ? 16'h0100 : 16'h0110;
        wrc(d);
        pulse((k == 2) ? 7 : 6 + 3 * k);
        chk(seen[0], d[8] && (d[4] == (k == 2)));
        pulse(4);
        pulse(5);
        pulse(8);
      end
    end
    // Lockout and wide count
    wrc(16'h0320);
    pulse(6);
    chk({busy, seen[0]}, 2'b11);
    pulse(6);
    chk(seen[0], 1'b0);
    pulse(4);
    chk({busy, seen[4]}, 2'b11);
    pulse(5);
    chk(busy, 1'b1);
    pulse(6);
    chk(seen[0], 1'b0);
    pulse(8);
    chk(busy, 1'b0);
    wrc(16'h0100);
    pulse(6);
    pulse(4);
    chk(busy, 1'b0);
    pulse(6);
    chk(seen[0], 1'b1);
    pulse(4);
    $display("test triggers done");
    results;
  end
endmodule : test_acquisition_command_register
